// *** hw/adcc_pkg.sv ***
package adcc_pkg;
    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CLKSEL_OFF = 8'h04;
    localparam logic [7:0] RESH_OFF = 8'h08;
    localparam logic [7:0] RESL_OFF = 8'h0c;
    localparam int START_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int EN_BIT = 5;
    localparam int FMT_BIT = 4;
    localparam int CH_MSB = 3;
    localparam int CH_W = 4;
    localparam int CKS_W = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] CLKSEL_RST = 3'h0;
    localparam logic [3:0] CH_COUNT = 4'hc;
    // ----------------------------------------------------------------
    // Conversion timing
    // ----------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int SAMPLE_TICKS = 4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 30;
    localparam int SETTLE_CYC =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SAMPLE = 2'b01,
        SEQ_TRIAL = 2'b10,
        SEQ_DECIDE = 2'b11
    } adcc_seq_e;
endpackage

// *** hw/adcc_conv_if.sv ***
interface adcc_conv_if;
    import adcc_pkg::*;
    logic start;
    logic abort;
    logic tick;
    logic cmp;
    logic busy;
    logic done;
    logic sample;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] result;
    modport ctrl (output start, abort, tick, cmp,
                  input busy, done, sample, trial, result);
    modport seq (input start, abort, tick, cmp,
                 output busy, done, sample, trial, result);
endinterface

// *** hw/adcc_clkdiv.sv ***
module adcc_clkdiv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [adcc_pkg::CKS_W-1:0] sel,
    output logic tick
);
    import adcc_pkg::*;
    logic [6:0] cnt_reg;
    logic [6:0] mask;

    // Divide by 2**sel; counter held at zero while idle
    assign mask = 7'((8'h01 << sel) - 8'h01);
    assign tick = run && ((cnt_reg & mask) == mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 7'h00;
        end else if (!run) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end
endmodule

// *** hw/adcc_sar_seq.sv ***
module adcc_sar_seq (
    input wire logic pclk,
    input wire logic presetn,
    adcc_conv_if.seq cv
);
    import adcc_pkg::*;
    adcc_seq_e state_reg;
    logic [RES_W-1:0] mask_reg;
    logic [RES_W-1:0] approx_reg;
    logic [3:0] cnt_reg;
    logic [RES_W-1:0] resolved;
    logic decide_now;

    assign resolved = cv.cmp ? approx_reg : (approx_reg & ~mask_reg);
    assign decide_now = cv.tick && (cnt_reg >= 4'(SETTLE_CYC));
    assign cv.busy = (state_reg != SEQ_IDLE);
    assign cv.sample = (state_reg == SEQ_SAMPLE);
    assign cv.trial = approx_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SEQ_IDLE;
            mask_reg <= '0;
            approx_reg <= '0;
            cnt_reg <= 4'h0;
        end else if (cv.abort) begin
            state_reg <= SEQ_IDLE;
        end else begin
            unique case (state_reg)
                SEQ_IDLE: begin
                    if (cv.start) begin
                        state_reg <= SEQ_SAMPLE;
                        mask_reg <= {1'b1, {(RES_W-1){1'b0}}};
                        approx_reg <= '0;
                        cnt_reg <= 4'h0;
                    end
                end
                SEQ_SAMPLE: begin
                    if (cv.tick) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == 4'(SAMPLE_TICKS - 1)) begin
                            state_reg <= SEQ_TRIAL;
                        end
                    end
                end
                SEQ_TRIAL: begin
                    if (cv.tick) begin
                        approx_reg <= approx_reg | mask_reg;
                        cnt_reg <= 4'h0;
                        state_reg <= SEQ_DECIDE;
                    end
                end
                SEQ_DECIDE: begin
                    if (cnt_reg < 4'(SETTLE_CYC)) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (decide_now) begin
                        approx_reg <= resolved;
                        mask_reg <= mask_reg >> 1;
                        state_reg <= mask_reg[0] ? SEQ_IDLE : SEQ_TRIAL;
                    end
                end
            endcase
        end
    end

    // End of the last bit decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cv.done <= 1'b0;
            cv.result <= '0;
        end else begin
            cv.done <= 1'b0;
            if (!cv.abort && state_reg == SEQ_DECIDE && decide_now
                    && mask_reg[0]) begin
                cv.done <= 1'b1;
                cv.result <= resolved;
            end
        end
    end
endmodule

// *** hw/adcc_top.sv ***
module adcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_in,
    output logic converter_power_en,
    output logic [adcc_pkg::CH_W-1:0] channel_select,
    output logic channel_connect,
    output logic sample_hold,
    output logic [adcc_pkg::RES_W-1:0] trial_code,
    output logic eoc_pulse
);
    import adcc_pkg::*;

    generate
        if (RES_W != 12) begin : g_bad_width
            $error("result layout serves twelve bits only");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic start_reg;
    logic enable_reg;
    logic format_reg;
    logic [CH_W-1:0] chan_reg;
    logic connect_reg;
    logic [CKS_W-1:0] clksel_reg;
    logic [7:0] result_high_reg;
    logic [7:0] result_low_reg;
    logic [31:0] prdata_reg;
    logic eoc_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;

    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic wr_clksel;
    logic start_fire;
    logic start_accept;
    logic tick;

    adcc_conv_if cv ();

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == CTRL_OFF) || (a == CLKSEL_OFF) ||
               (a == RESH_OFF) || (a == RESL_OFF);
    endfunction

    function automatic logic chan_exists(input logic [CH_W-1:0] c);
        return c < CH_COUNT;
    endfunction

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access_ph && !addr_mapped(paddr);
    assign prdata = prdata_reg;
    assign wr_ctrl = access_ph && pwrite && (paddr == CTRL_OFF);
    assign wr_clksel = access_ph && pwrite && (paddr == CLKSEL_OFF);

    function automatic logic [31:0] read_word(
        input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            CTRL_OFF: begin
                w[START_BIT] = start_reg;
                w[BUSY_BIT] = cv.busy;
                w[EN_BIT] = enable_reg;
                w[FMT_BIT] = format_reg;
                w[CH_MSB:0] = chan_reg;
            end
            CLKSEL_OFF: w[CKS_W-1:0] = clksel_reg;
            RESH_OFF: w[7:0] = result_high_reg;
            RESL_OFF: w[7:0] = result_low_reg;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Read data is captured in the setup phase, ready in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : read_word(paddr);
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= CTRL_RST[START_BIT];
            enable_reg <= CTRL_RST[EN_BIT];
            format_reg <= CTRL_RST[FMT_BIT];
            chan_reg <= CTRL_RST[CH_MSB:0];
        end else if (wr_ctrl) begin
            // Busy bit position is not stored
            start_reg <= pwdata[START_BIT];
            enable_reg <= pwdata[EN_BIT];
            format_reg <= pwdata[FMT_BIT];
            chan_reg <= pwdata[CH_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            connect_reg <= 1'b0;
        end else if (wr_ctrl) begin
            connect_reg <= pwdata[EN_BIT] &&
                           chan_exists(pwdata[CH_MSB:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clksel_reg <= CLKSEL_RST;
        end else if (wr_clksel) begin
            clksel_reg <= pwdata[CKS_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Start pulse and sequencer hookup
    // ----------------------------------------------------------------
    // High then low on the start bit completes the trigger
    assign start_fire = wr_ctrl && start_reg && !pwdata[START_BIT];
    // A write that clears enable and start together must not start
    assign start_accept = start_fire && enable_reg && !cv.abort
                          && !cv.busy;
    assign cv.start = start_accept;
    assign cv.abort = wr_ctrl && !pwdata[EN_BIT];
    assign cv.tick = tick;
    assign cv.cmp = cmp_sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else begin
            cmp_meta_reg <= cmp_in;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    adcc_clkdiv u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(cv.busy),
        .sel(clksel_reg),
        .tick(tick)
    );

    adcc_sar_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .cv(cv)
    );

    // ----------------------------------------------------------------
    // Result registers and completion
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_reg <= 8'h00;
            result_low_reg <= 8'h00;
        end else if (cv.done) begin
            if (!format_reg) begin
                result_high_reg <= cv.result[11:4];
                result_low_reg <= {cv.result[3:0], 4'h0};
            end else begin
                result_high_reg <= {4'h0, cv.result[11:8]};
                result_low_reg <= cv.result[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_reg <= 1'b0;
        end else begin
            eoc_reg <= cv.done;
        end
    end

    assign eoc_pulse = eoc_reg;
    assign converter_power_en = enable_reg;
    assign channel_select = chan_reg;
    assign channel_connect = connect_reg;
    assign sample_hold = cv.sample;
    assign trial_code = cv.trial;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [7:0] gap_cnt_reg;
    logic gap_valid_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_reg <= 8'h00;
            gap_valid_reg <= 1'b0;
        end else begin
            gap_cnt_reg <= tick ? 8'h00 : gap_cnt_reg + 8'h01;
            if (wr_clksel || !cv.busy) begin
                gap_valid_reg <= 1'b0;
            end else if (tick) begin
                gap_valid_reg <= 1'b1;
            end
        end
    end

    sequence s_accepted;
        start_accept;
    endsequence

    sequence s_finished;
        cv.done ##1 eoc_pulse;
    endsequence

    start_busy_a: assert property (
        s_accepted |=> cv.busy ##1 (cv.busy || cv.done))
        else $error("busy did not follow an accepted start");

    busy_cause_a: assert property (
        $rose(cv.busy) |-> $past(start_fire) && $past(enable_reg))
        else $error("busy rose without a complete start pulse");

    busy_clear_a: assert property (
        cv.done |-> !cv.busy)
        else $error("busy still set at completion");

    busy_ro_a: assert property (
        wr_ctrl && cv.busy && pwdata[EN_BIT] |=> cv.busy || cv.done)
        else $error("register write altered busy");

    enable_bit_a: assert property (
        wr_ctrl |=> converter_power_en == $past(pwdata[EN_BIT]))
        else $error("enable bit not applied");

    power_down_a: assert property (
        wr_ctrl && !pwdata[EN_BIT] |=> !converter_power_en && !cv.busy
        ##1 !cv.done)
        else $error("converter still active after disable");

    result_hold_a: assert property (
        !cv.done |=> $stable(result_high_reg) && $stable(result_low_reg))
        else $error("result changed without completion");

    left_fmt_a: assert property (
        cv.done && !format_reg |=> result_high_reg ==
        $past(cv.result[11:4]) && result_low_reg[7:4] ==
        $past(cv.result[3:0]))
        else $error("left aligned result misplaced");

    right_fmt_a: assert property (
        cv.done && format_reg |=> result_high_reg[3:0] ==
        $past(cv.result[11:8]) && result_low_reg ==
        $past(cv.result[7:0]) && result_high_reg[7:4] == 4'h0)
        else $error("right aligned result misplaced");

    conv_len_a: assert property (
        $fell(cv.busy) && !$past(cv.abort) |-> $past(cv.busy, 8))
        else $error("conversion ended too early");

    chan_sel_a: assert property (
        wr_ctrl |=> channel_select == $past(pwdata[CH_MSB:0]))
        else $error("channel field not applied");

    chan_float_a: assert property (
        !chan_exists(channel_select) |-> !channel_connect)
        else $error("nonexistent channel connected");

    done_irq_a: assert property (
        cv.done |-> s_finished)
        else $error("completion request missing");

    tick_rate_a: assert property (
        tick && gap_valid_reg |-> gap_cnt_reg ==
        8'((8'h01 << clksel_reg) - 8'h01))
        else $error("conversion clock rate wrong");

    reset_zero_a: assert property (
        $rose(presetn) |-> !enable_reg && !cv.busy && chan_reg == 4'h0)
        else $error("control not cleared by reset");
endmodule

// *** tb/test_adc_conversion_control.sv ***
module test_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int LIMIT = 90000;
    logic pclk, presetn, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, exp_hi, exp_lo;
    logic pready, pslverr, cmp_in, converter_power_en, err;
    logic [CH_W-1:0] channel_select;
    logic channel_connect, sample_hold, eoc_pulse;
    logic [RES_W-1:0] trial_code, target;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'h6cefa58c;
    logic [11:0] v;
    logic [2:0] cks;
    logic fmt;
    logic [7:0] f;

    adcc_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_in(cmp_in), .converter_power_en(converter_power_en),
        .channel_select(channel_select),
        .channel_connect(channel_connect), .sample_hold(sample_hold),
        .trial_code(trial_code), .eoc_pulse(eoc_pulse)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Analog input seen through an ideal comparator
    always @(posedge pclk) begin
        cmp_in <= (target >= trial_code);
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic final_report();
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h want %h",
                     $time, m, got, exp);
            fails++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, m);
        chk({31'h0, err}, 32'h0, "error on mapped read");
    endtask

    function automatic logic [31:0] hi_of(input logic [11:0] x,
                                          input logic fm);
        return fm ? {28'h0, x[11:8]} : {24'h0, x[11:4]};
    endfunction

    function automatic logic [31:0] lo_of(input logic [11:0] x,
                                          input logic fm);
        return fm ? {24'h0, x[7:0]} : {24'h0, x[3:0], 4'h0};
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One full conversion with checks on start, busy, completion and result
    task automatic convert(input logic [11:0] x, input logic fm,
                           input logic [2:0] ck);
        int n;
        n = 0;
        f = {3'b000, fm, 4'h0};
        target <= x;
        apb(1'b1, CLKSEL_OFF, {29'h0, ck});
        apb(1'b1, CTRL_OFF, {24'h0, 8'h60 | f});
        rdchk(CTRL_OFF, {24'h0, 8'h20 | f}, "busy written");
        apb(1'b1, CTRL_OFF, {24'h0, 8'ha0 | f});
        rdchk(CTRL_OFF, {24'h0, 8'ha0 | f}, "start high only");
        apb(1'b1, CTRL_OFF, {24'h0, 8'h20 | f});
        #1;
        chk({31'h0, sample_hold}, 32'h1, "sampling after start");
        chk({20'h0, trial_code}, 32'h0, "trial cleared at start");
        rdchk(CTRL_OFF, {24'h0, 8'h60 | f}, "busy after start");
        apb(1'b1, CTRL_OFF, {24'h0, 8'h60 | f});
        rdchk(CTRL_OFF, {24'h0, 8'h60 | f}, "busy kept on write");
        while (eoc_pulse !== 1'b1 && n < 8000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({31'h0, eoc_pulse}, 32'h1, "no completion");
        chk({20'h0, trial_code}, {20'h0, x}, "final trial");
        chk({31'h0, n + 4 >= 15 * (1 << ck)}, 32'h1, "too fast");
        wait_cyc(1);
        chk({31'h0, eoc_pulse}, 32'h0, "eoc wider than one");
        rdchk(CTRL_OFF, {24'h0, 8'h20 | f}, "busy after done");
        exp_hi = hi_of(x, fm);
        exp_lo = lo_of(x, fm);
        rdchk(RESH_OFF, exp_hi, "result high");
        rdchk(RESL_OFF, exp_lo, "result low");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        target = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_cyc(1);
        chk({31'h0, converter_power_en}, 32'h0, "power at reset");
        rdchk(CTRL_OFF, {24'h0, CTRL_RST}, "control reset");
        rdchk(CLKSEL_OFF, {29'h0, CLKSEL_RST}, "clock select reset");
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b1, 8'h10, 32'hff);
        chk({31'h0, err}, 32'h1, "unmapped write error");
        // Start pulse while disabled must not run
        apb(1'b1, CTRL_OFF, 32'h80);
        apb(1'b1, CTRL_OFF, 32'h00);
        wait_cyc(3);
        chk({31'h0, sample_hold}, 32'h0, "sampling while off");
        rdchk(CTRL_OFF, 32'h0, "start while off");
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, CTRL_OFF, 32'h20 | c);
            wait_cyc(1);
            chk({28'h0, channel_select}, c, "channel code");
            chk({31'h0, channel_connect}, {31'h0, c < 12}, "connect");
            chk({31'h0, converter_power_en}, 32'h1, "power on");
        end
        apb(1'b1, CTRL_OFF, 32'h0f);
        wait_cyc(1);
        chk({31'h0, converter_power_en}, 32'h0, "power off");
        chk({31'h0, channel_connect}, 32'h0, "connect while off");
        for (int i = 0; i < 10; i++) begin
            v = $random(seed);
            if (i == 8) v = 12'h000;
            if (i == 9) v = 12'hfff;
            cks = (i < 8) ? i[2:0] : 3'h0;
            convert(v, i[0], cks);
        end
        apb(1'b1, RESH_OFF, $random(seed));
        rdchk(RESH_OFF, exp_hi, "result high written");
        // Disable in mid conversion keeps the old results
        target <= $random(seed);
        apb(1'b1, CTRL_OFF, 32'ha0);
        apb(1'b1, CTRL_OFF, 32'h20);
        wait_cyc(10);
        apb(1'b1, CTRL_OFF, 32'h00);
        wait_cyc(1);
        chk({31'h0, converter_power_en}, 32'h0, "power after abort");
        rdchk(CTRL_OFF, 32'h0, "busy after abort");
        for (int k = 0; k < 150; k++) begin
            wait_cyc(1);
            if (eoc_pulse !== 1'b0) chk(32'h1, 32'h0, "eoc after abort");
        end
        rdchk(RESH_OFF, exp_hi, "high kept");
        rdchk(RESL_OFF, exp_lo, "low kept");
        final_report();
    end
endmodule
